// *** hw/efs_consts.vh ***
// constants for the efuse fault supervisor
`ifndef EFS_CONSTS_VH
`define EFS_CONSTS_VH

// register byte offsets
`define EFS_OFS_CTRL 8'h00
`define EFS_OFS_STAT 8'h04
`define EFS_OFS_MASK 8'h08
`define EFS_OFS_OTTH 8'h0C
`define EFS_OFS_TEMP 8'h10
`define EFS_OFS_STATE 8'h14
`define EFS_OFS_LOAD_CURRENT_MONITOR 8'h18

// ctrl fields
`define EFS_CTRL_TMDIS 0
`define EFS_CTRL_RETRY 1
`define EFS_CTRL_W 2

// status / mask fields
`define EFS_ST_TRAN 0
`define EFS_ST_SPF 1
`define EFS_ST_TSD 2
`define EFS_ST_CB 3
`define EFS_ST_W 4

// reset values
`define EFS_CTRL_RST 2'h0
`define EFS_MASK_RST 4'hF
`define EFS_OTTH_RST 8'hFF
`define EFS_OTHYS_DEF 8'h0A

// synchronised pin vector layout
`define EFS_PIN_EN 0
`define EFS_PIN_TRAN 1
`define EFS_PIN_FT 2
`define EFS_PIN_LOAD_CURRENT_MONITOR 3
`define EFS_PIN_STARTUP_LIMIT_SENSE 4
`define EFS_PIN_BKP 5
`define EFS_PIN_IRGND 6
`define EFS_PIN_TSD 7
`define EFS_PIN_TCOOL 8
`define EFS_PIN_INRUSH 9
`define EFS_PIN_N 10

// timing
`define EFS_CLK_MHZ 125
`define EFS_RETRY_US 100

`endif

// *** hw/efs_fault_supervisor.v ***
// fault supervisor: single point failure, thermal shutdown, current monitor gating
`include "efs_consts.vh"

// Operation
// - set input transient flag when a supply transient is suppressed from tripping
// - transient mask disable bit stops suppression of transients on fast trip
// - monitor pin above reference (open pin) forces circuit-breaker shutdown
// - backup overcurrent without monitor detection declares latched single point fail
// - single point fail: switch off, fault indicator, status flag, alert
// - start-up sense above reference (open pin) engages current limiting
// - start-up backup overcurrent without limit detection latches single point fail
// - backup overcurrent with no primary detection on either pin is single point fail
// - reference shorted to ground gives limiting or breaker action at any current
// - current monitor output reads zero during inrush, measured value in steady state
// - thermal overload shuts down, then latches off or auto-restarts per retry setting
// - default thermal limit plus host threshold; trip on whichever is reached
// - die temperature conversion result returned by the temperature read register
// - latch-off versus auto-restart follows the restart policy setting
module efs_fault_supervisor #(
   parameter RETRY_CYCLES = `EFS_RETRY_US * `EFS_CLK_MHZ,
   parameter TEMP_W = 8,
   parameter LOAD_CURRENT_MONITOR_W = 12
) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [7:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output wire [31:0] hrdata,
   input wire enable_pin,
   input wire transient_det,
   input wire fast_trip_raw,
   input wire load_current_monitor_over,
   input wire startup_limit_sense_over,
   input wire backup_overcurrent_level_over,
   input wire limit_reference_grounded,
   input wire thermal_shutdown_hot,
   input wire thermal_shutdown_cool,
   input wire inrush_active,
   input wire temp_adc_valid,
   input wire [TEMP_W-1:0] temp_adc_data,
   input wire [LOAD_CURRENT_MONITOR_W-1:0] load_current_monitor_meas,
   output wire switch_on,
   output wire current_limit_en,
   output wire fast_trip,
   output wire fault_indicator,
   output wire smb_alert_n,
   output wire irq,
   output wire [LOAD_CURRENT_MONITOR_W-1:0] load_current_monitor_out
);

   localparam CNT_W = 24;
   localparam [31:0] RETRY_LAST = RETRY_CYCLES - 1;
   localparam [CNT_W-1:0] RETRY_MAX = RETRY_LAST[CNT_W-1:0];
   localparam [1:0] ST_OFF = 2'h0;
   localparam [1:0] ST_ON = 2'h1;
   localparam [1:0] ST_FAULT = 2'h2;
   localparam [1:0] ST_RETRY = 2'h3;

   // two-stage synchronisers for analog comparator pins
   // only the second stage reads the first, so no metastable level leaks on
   wire [`EFS_PIN_N-1:0] pin_raw;
   reg [`EFS_PIN_N-1:0] pin_meta_reg;
   reg [`EFS_PIN_N-1:0] pin_sync_reg;
   // bit order follows the pin vector layout of the header
   assign pin_raw = {inrush_active, thermal_shutdown_cool, thermal_shutdown_hot,
                     limit_reference_grounded, backup_overcurrent_level_over,
                     startup_limit_sense_over, load_current_monitor_over,
                     fast_trip_raw, transient_det, enable_pin};

   genvar gi;
   generate
      for (gi = 0; gi < `EFS_PIN_N; gi = gi + 1) begin : g_sync
         always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               pin_meta_reg[gi] <= 1'b0;
               pin_sync_reg[gi] <= 1'b0;
            end else begin
               pin_meta_reg[gi] <= pin_raw[gi];
               pin_sync_reg[gi] <= pin_meta_reg[gi];
            end
         end
      end
   endgenerate

   wire en_s = pin_sync_reg[`EFS_PIN_EN];
   wire tran_s = pin_sync_reg[`EFS_PIN_TRAN];
   wire ft_s = pin_sync_reg[`EFS_PIN_FT];
   wire load_current_monitor_s = pin_sync_reg[`EFS_PIN_LOAD_CURRENT_MONITOR];
   wire startup_limit_sense_s = pin_sync_reg[`EFS_PIN_STARTUP_LIMIT_SENSE];
   wire bkp_s = pin_sync_reg[`EFS_PIN_BKP];
   wire irgnd_s = pin_sync_reg[`EFS_PIN_IRGND];
   wire hot_s = pin_sync_reg[`EFS_PIN_TSD];
   wire cool_s = pin_sync_reg[`EFS_PIN_TCOOL];
   wire inrush_s = pin_sync_reg[`EFS_PIN_INRUSH];

   // registers
   reg [`EFS_CTRL_W-1:0] ctrl_reg;
   reg [`EFS_ST_W-1:0] status_reg;
   reg [`EFS_ST_W-1:0] status_next;
   reg [`EFS_ST_W-1:0] mask_reg;
   reg [TEMP_W-1:0] ot_thr_reg;
   reg [TEMP_W-1:0] temp_reg;
   reg [LOAD_CURRENT_MONITOR_W-1:0] load_current_monitor_reg;
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg spf_reg;
   reg tsd_reg;
   reg cb_reg;
   // enable as software sees it, one cycle behind the state machine
   reg en_d_reg;
   reg [CNT_W-1:0] retry_cnt_reg;
   reg [CNT_W-1:0] retry_cnt_next;

   wire tmdis = ctrl_reg[`EFS_CTRL_TMDIS];
   wire auto_retry = ctrl_reg[`EFS_CTRL_RETRY];

   // transient suppression of the fast-trip path
   // the flag marks each cycle in which a raw trip was held back
   wire tran_masked = ft_s & tran_s & ~tmdis;
   assign fast_trip = ft_s & ~tran_masked & state_reg == ST_ON;
   wire tran_event = tran_masked;

   // primary detections; a grounded reference means zero threshold
   // open pins read over the reference and so trip like a real overload
   wire load_current_monitor_trip = load_current_monitor_s | irgnd_s;
   wire startup_limit_sense_trip = startup_limit_sense_s | irgnd_s;
   assign current_limit_en = inrush_s & startup_limit_sense_trip & state_reg == ST_ON;
   wire cb_event = ~inrush_s & load_current_monitor_trip & state_reg == ST_ON;

   // backup comparison against whichever primary path applies
   wire spf_ss = ~inrush_s & bkp_s & ~load_current_monitor_s;
   wire spf_su = inrush_s & bkp_s & ~startup_limit_sense_s;
   wire spf_any = bkp_s & ~load_current_monitor_s & ~startup_limit_sense_s & ~ft_s;
   wire spf_event = (spf_ss | spf_su | spf_any) & state_reg == ST_ON;

   // temperature threshold: default hot pin or host threshold, lower wins
   wire ot_hot = temp_reg >= ot_thr_reg;
   wire [TEMP_W:0] thr_ext = {1'b0, ot_thr_reg};
   wire [TEMP_W:0] hys_ext = {1'b0, `EFS_OTHYS_DEF};
   wire [TEMP_W:0] thr_low = thr_ext - hys_ext;
   // a threshold below the hysteresis never reads cool; only enable low then clears the thermal latch
   wire ot_cool = ~thr_low[TEMP_W] & ({1'b0, temp_reg} < thr_low);
   // only a running switch trips: a late trip while leaving a fault would
   // latch in the off state with nothing left to clear it
   wire tsd_event = (hot_s | ot_hot) & state_reg == ST_ON & ~tsd_reg;
   wire temp_ok = cool_s & ot_cool & ~hot_s;

   // restart triggers: enable low or retry timer expiry
   // the counter parks at its last count until the die has cooled
   wire en_low = ~en_s;
   wire retry_done = retry_cnt_reg == RETRY_MAX;

   // control sequence
   always @* begin
      state_next = state_reg;
      retry_cnt_next = retry_cnt_reg;
      case (state_reg)
         ST_OFF: begin
            if (en_s && !spf_reg && !tsd_reg && !cb_reg)
               state_next = ST_ON;
         end
         ST_ON: begin
            if (en_low)
               state_next = ST_OFF;
            else if (spf_event || tsd_event || cb_event) begin
               state_next = ST_FAULT;
               retry_cnt_next = {CNT_W{1'b0}};
            end
         end
         ST_FAULT: begin
            // latch-off policy waits here for the enable pin
            if (en_low)
               state_next = ST_OFF;
            else if (auto_retry)
               state_next = ST_RETRY;
         end
         ST_RETRY: begin
            // a policy change while waiting falls back to latch-off
            if (en_low)
               state_next = ST_OFF;
            else if (!auto_retry)
               state_next = ST_FAULT;
            else if (retry_done) begin
               if (temp_ok || !tsd_reg)
                  state_next = ST_OFF;
            end else
               retry_cnt_next = retry_cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
         end
         default: state_next = ST_OFF;
      endcase
   end

   // leaving fault via the off state clears latches
   wire restart = (state_reg == ST_FAULT || state_reg == ST_RETRY) && state_next == ST_OFF;
   wire tsd_clear = restart & (temp_ok | en_low);

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= ST_OFF;
         retry_cnt_reg <= {CNT_W{1'b0}};
         spf_reg <= 1'b0;
         tsd_reg <= 1'b0;
         cb_reg <= 1'b0;
         en_d_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         retry_cnt_reg <= retry_cnt_next;
         en_d_reg <= en_s;
         // a set wins over a clear in the same cycle
         if (spf_event)
            spf_reg <= 1'b1;
         else if (restart)
            spf_reg <= 1'b0;
         if (tsd_event)
            tsd_reg <= 1'b1;
         else if (tsd_clear)
            tsd_reg <= 1'b0;
         // breaker latch shares the restart path of the other faults
         if (cb_event)
            cb_reg <= 1'b1;
         else if (restart)
            cb_reg <= 1'b0;
      end
   end

   // latched faults hold the switch off
   assign switch_on = state_reg == ST_ON;
   assign fault_indicator = spf_reg | tsd_reg | cb_reg;

   // current monitor gated to zero during inrush
   // gated in the register so the output never shows a half-settled value
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         load_current_monitor_reg <= {LOAD_CURRENT_MONITOR_W{1'b0}};
      else if (inrush_s)
         load_current_monitor_reg <= {LOAD_CURRENT_MONITOR_W{1'b0}};
      else
         load_current_monitor_reg <= load_current_monitor_meas;
   end
   assign load_current_monitor_out = load_current_monitor_reg;

   // converter result kept for the temperature read
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         temp_reg <= {TEMP_W{1'b0}};
      else if (temp_adc_valid)
         temp_reg <= temp_adc_data;
   end

   // bus slave: zero wait states, always okay
   // read data registered at the address phase, so the data phase needs no wait
   reg ph_wr_reg;
   reg [7:0] ph_addr_reg;
   reg [31:0] rdata_reg;
   reg [31:0] rd_mux;
   wire acc = hsel & htrans[1] & hready;
   wire rd_acc = acc & ~hwrite;
   wire stat_rd = rd_acc & haddr == `EFS_OFS_STAT;
   // state readback: latches, state code, enable as last sampled
   wire [5:0] state_word = {cb_reg, tsd_reg, spf_reg, state_reg, en_d_reg};

   always @* begin
      rd_mux = 32'h0000_0000;
      case (haddr)
         `EFS_OFS_CTRL: rd_mux[`EFS_CTRL_W-1:0] = ctrl_reg;
         `EFS_OFS_STAT: rd_mux[`EFS_ST_W-1:0] = status_reg;
         `EFS_OFS_MASK: rd_mux[`EFS_ST_W-1:0] = mask_reg;
         `EFS_OFS_OTTH: rd_mux[TEMP_W-1:0] = ot_thr_reg;
         `EFS_OFS_TEMP: rd_mux[TEMP_W-1:0] = temp_reg;
         `EFS_OFS_STATE: rd_mux[5:0] = state_word;
         `EFS_OFS_LOAD_CURRENT_MONITOR: rd_mux[LOAD_CURRENT_MONITOR_W-1:0] = load_current_monitor_reg;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_wr_reg <= 1'b0;
         ph_addr_reg <= 8'h00;
         rdata_reg <= 32'h0000_0000;
      end else begin
         ph_wr_reg <= acc & hwrite;
         if (acc)
            ph_addr_reg <= haddr;
         if (rd_acc)
            rdata_reg <= rd_mux;
      end
   end

   // writes land at the data phase edge, while hwdata stands
   wire wr_ctrl = ph_wr_reg & ph_addr_reg == `EFS_OFS_CTRL;
   wire wr_mask = ph_wr_reg & ph_addr_reg == `EFS_OFS_MASK;
   wire wr_otth = ph_wr_reg & ph_addr_reg == `EFS_OFS_OTTH;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= `EFS_CTRL_RST;
         // mask opens fully so a fault alerts before software runs
         mask_reg <= `EFS_MASK_RST;
         ot_thr_reg <= `EFS_OTTH_RST;
      end else begin
         if (wr_ctrl)
            ctrl_reg <= hwdata[`EFS_CTRL_W-1:0];
         if (wr_mask)
            mask_reg <= hwdata[`EFS_ST_W-1:0];
         if (wr_otth)
            ot_thr_reg <= hwdata[TEMP_W-1:0];
      end
   end

   // sticky status, cleared by a read; a new event wins over the clear
   always @* begin
      status_next = stat_rd ? {`EFS_ST_W{1'b0}} : status_reg;
      if (tran_event)
         status_next[`EFS_ST_TRAN] = 1'b1;
      if (spf_event)
         status_next[`EFS_ST_SPF] = 1'b1;
      if (tsd_event)
         status_next[`EFS_ST_TSD] = 1'b1;
      if (cb_event)
         status_next[`EFS_ST_CB] = 1'b1;
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         status_reg <= {`EFS_ST_W{1'b0}};
      else
         status_reg <= status_next;
   end

   // level interrupt; the alert pin is its active-low copy
   assign irq = |(status_reg & mask_reg);
   assign smb_alert_n = ~irq;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_reg;

endmodule

// *** tb/efs_sup_asserts.sv ***
// assertion checker bound to the fault supervisor ports
module efs_sup_asserts #(
   parameter LOAD_CURRENT_MONITOR_W = 12
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic load_current_monitor_over,
   input wire logic startup_limit_sense_over,
   input wire logic backup_overcurrent_level_over,
   input wire logic fast_trip_raw,
   input wire logic thermal_shutdown_hot,
   input wire logic inrush_active,
   input wire logic [LOAD_CURRENT_MONITOR_W-1:0] load_current_monitor_meas,
   input wire logic switch_on,
   input wire logic fault_indicator,
   input wire logic smb_alert_n,
   input wire logic irq,
   input wire logic [LOAD_CURRENT_MONITOR_W-1:0] load_current_monitor_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // backup trip with every primary path quiet, held past the 2-stage sync
   sequence s_spf;
      (backup_overcurrent_level_over && !load_current_monitor_over
         && !startup_limit_sense_over && !fast_trip_raw && switch_on)[*3];
   endsequence
   sequence s_off;
      ##[0:3] !switch_on;
   endsequence
   AST_SPF: assert property (s_spf |-> s_off)
      else $error("backup overcurrent did not open the switch");
   AST_CB: assert property ((load_current_monitor_over && switch_on)[*3] |-> s_off)
      else $error("monitor over reference did not open the switch");
   AST_TSD: assert property ((thermal_shutdown_hot && switch_on)[*3] |-> s_off)
      else $error("hot die did not open the switch");
   AST_ALERT: assert property (smb_alert_n == !irq)
      else $error("alert line does not follow irq");
   AST_FLT: assert property ($rose(fault_indicator) |-> !switch_on && !smb_alert_n)
      else $error("fault without switch off and alert");
   AST_HOLD: assert property (fault_indicator |-> !switch_on)
      else $error("switch on while fault latched");
   AST_RESTART: assert property ($rose(switch_on) |-> !fault_indicator)
      else $error("switch on with fault still latched");
   AST_IMON0: assert property (inrush_active[*5] |-> load_current_monitor_out == 0)
      else $error("monitor output nonzero during inrush");
   AST_IMONSS: assert property ((!inrush_active && $stable(load_current_monitor_meas))[*5]
      |-> load_current_monitor_out == load_current_monitor_meas)
      else $error("monitor output differs from measurement");
endmodule

bind efs_fault_supervisor efs_sup_asserts #(.LOAD_CURRENT_MONITOR_W(LOAD_CURRENT_MONITOR_W)) i_asserts (.hclk, .hresetn,
   .load_current_monitor_over, .startup_limit_sense_over, .backup_overcurrent_level_over,
   .fast_trip_raw, .thermal_shutdown_hot, .inrush_active, .load_current_monitor_meas, .switch_on,
   .fault_indicator, .smb_alert_n, .irq, .load_current_monitor_out);

// *** tb/efs_host.sv ***
// host model: AHB-Lite master reaching the supervisor registers
module efs_host (
   input wire logic hclk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [7:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   // host sets mask disable and threshold; no latency assumed, waits on hready
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask
endmodule

// *** tb/efs_fault_supervisor_tb.sv ***
// self-checking bench for the fault supervisor
`include "efs_consts.vh"
module efs_fault_supervisor_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel, hwrite, hready, hreadyout, hresp;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, q;
   logic enable_pin = 1'b0, transient_det = 1'b0, fast_trip_raw = 1'b0;
   logic load_current_monitor_over = 1'b0, backup_overcurrent_level_over = 1'b0;
   logic startup_limit_sense_over = 1'b0, limit_reference_grounded = 1'b0;
   logic thermal_shutdown_hot = 1'b0, thermal_shutdown_cool = 1'b1, inrush_active = 1'b0;
   logic temp_adc_valid = 1'b0;
   logic [7:0] temp_adc_data = 8'h00;
   logic [11:0] load_current_monitor_meas = 12'h000, load_current_monitor_out;
   logic switch_on, current_limit_en, fast_trip, fault_indicator, smb_alert_n, irq;
   int miscompares = 0, check_count = 0, cyc = 0;
   assign hready = hreadyout;
   always #4 hclk = ~hclk;
   // short retry count keeps the run brief
   efs_fault_supervisor #(.RETRY_CYCLES(20)) i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .enable_pin,
      .transient_det, .fast_trip_raw, .load_current_monitor_over,
      .startup_limit_sense_over, .backup_overcurrent_level_over,
      .limit_reference_grounded, .thermal_shutdown_hot, .thermal_shutdown_cool,
      .inrush_active, .temp_adc_valid, .temp_adc_data, .load_current_monitor_meas, .switch_on,
      .current_limit_en, .fast_trip, .fault_indicator, .smb_alert_n, .irq,
      .load_current_monitor_out);
   efs_host i_host (.hclk, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
      i_host.xfer(1'b0, a, 32'h0, q);
      chk(n, e, q);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_host.xfer(1'b1, a, d, q);
   endtask
   // sampled mid-cycle so the edge's updates have landed
   task automatic sw(input logic v, input string n);
      for (int i = 0; i < 60 && switch_on !== v; i++) @(negedge hclk);
      chk(n, 32'(v), 32'(switch_on));
   endtask
   task automatic restart();
      @(posedge hclk) enable_pin <= 1'b0;
      repeat (6) @(posedge hclk);
      enable_pin <= 1'b1;
      sw(1'b1, "switch on");
   endtask
   task automatic t_reset();
      rd(`EFS_OFS_CTRL, 32'(`EFS_CTRL_RST), "ctrl");
      rd(`EFS_OFS_MASK, 32'(`EFS_MASK_RST), "mask");
      rd(`EFS_OFS_OTTH, 32'(`EFS_OTTH_RST), "threshold");
      rd(8'h1C, 32'h0, "unmapped");
      chk("hresp", 32'h0, 32'(hresp));
      chk("hreadyout", 32'h1, 32'(hreadyout));
      chk("no limit", 32'h0, 32'(current_limit_en));
      $display("test reset done");
   endtask
   task automatic t_load_current_monitor();
      @(posedge hclk) inrush_active <= 1'b1;
      load_current_monitor_meas <= 12'hABC;
      repeat (8) @(posedge hclk);
      chk("load_current_monitor inrush", 32'h0, 32'(load_current_monitor_out));
      inrush_active <= 1'b0;
      repeat (8) @(posedge hclk);
      chk("load_current_monitor steady", 32'hABC, 32'(load_current_monitor_out));
      $display("test load_current_monitor done");
   endtask
   task automatic t_tran();
      @(posedge hclk) transient_det <= 1'b1;
      fast_trip_raw <= 1'b1;
      repeat (5) @(posedge hclk);
      chk("fast_trip", 32'h0, 32'(fast_trip));
      wr(`EFS_OFS_MASK, 32'h0);
      @(negedge hclk) chk("irq masked", 32'h0, 32'(irq));
      wr(`EFS_OFS_MASK, 32'hF);
      @(negedge hclk) chk("irq", 32'h1, 32'(irq));
      @(posedge hclk) transient_det <= 1'b0;
      fast_trip_raw <= 1'b0;
      repeat (4) @(posedge hclk);
      chk("switch kept", 32'h1, 32'(switch_on));
      rd(`EFS_OFS_STAT, 32'h1 << `EFS_ST_TRAN, "status tran");
      rd(`EFS_OFS_STAT, 32'h0, "status cleared");
      chk("irq cleared", 32'h0, 32'(irq));
      wr(`EFS_OFS_CTRL, 32'h1 << `EFS_CTRL_TMDIS);
      @(posedge hclk) transient_det <= 1'b1;
      fast_trip_raw <= 1'b1;
      repeat (4) @(posedge hclk);
      @(negedge hclk) chk("unmasked trip", 32'h1, 32'(fast_trip));
      @(posedge hclk) transient_det <= 1'b0;
      fast_trip_raw <= 1'b0;
      wr(`EFS_OFS_CTRL, 32'h0);
      rd(`EFS_OFS_STAT, 32'h0, "no tran flag");
      $display("test transient done");
   endtask
   task automatic t_faults();
      int b[3] = '{`EFS_ST_SPF, `EFS_ST_CB, `EFS_ST_TSD};
      for (int k = 0; k < 3; k++) begin
         restart();
         @(posedge hclk) backup_overcurrent_level_over <= (k == 0);
         load_current_monitor_over <= (k == 1);
         thermal_shutdown_hot <= (k == 2);
         thermal_shutdown_cool <= (k != 2);
         sw(1'b0, "switch off");
         chk("fault_indicator", 32'h1, 32'(fault_indicator));
         chk("smb_alert_n", 32'h0, 32'(smb_alert_n));
         @(posedge hclk) backup_overcurrent_level_over <= 1'b0;
         load_current_monitor_over <= 1'b0;
         thermal_shutdown_hot <= 1'b0;
         thermal_shutdown_cool <= 1'b1;
         repeat (40) @(posedge hclk);
         chk("latched off", 32'h0, 32'(switch_on));
         rd(`EFS_OFS_STAT, 32'h1 << b[k], "status fault");
      end
      $display("test faults done");
   endtask
   task automatic t_limit();
      restart();
      @(posedge hclk) inrush_active <= 1'b1;
      startup_limit_sense_over <= 1'b1;
      repeat (4) @(posedge hclk);
      @(negedge hclk) chk("limit open sense", 32'h1, 32'(current_limit_en));
      @(posedge hclk) startup_limit_sense_over <= 1'b0;
      limit_reference_grounded <= 1'b1;
      repeat (4) @(posedge hclk);
      @(negedge hclk) chk("limit grounded ref", 32'h1, 32'(current_limit_en));
      chk("limit keeps switch", 32'h1, 32'(switch_on));
      @(posedge hclk) inrush_active <= 1'b0;
      sw(1'b0, "grounded breaker");
      @(posedge hclk) limit_reference_grounded <= 1'b0;
      rd(`EFS_OFS_STAT, 32'h1 << `EFS_ST_CB, "status breaker");
      restart();
      @(posedge hclk) inrush_active <= 1'b1;
      backup_overcurrent_level_over <= 1'b1;
      sw(1'b0, "start-up spf");
      chk("spf indicator", 32'h1, 32'(fault_indicator));
      @(posedge hclk) inrush_active <= 1'b0;
      backup_overcurrent_level_over <= 1'b0;
      rd(`EFS_OFS_STAT, 32'h1 << `EFS_ST_SPF, "status start-up spf");
      $display("test limit done");
   endtask
   task automatic t_temp();
      restart();
      @(posedge hclk) temp_adc_valid <= 1'b1;
      temp_adc_data <= 8'h55;
      @(posedge hclk) temp_adc_valid <= 1'b0;
      rd(`EFS_OFS_TEMP, 32'h55, "temperature");
      chk("below limit", 32'h1, 32'(switch_on));
      wr(`EFS_OFS_OTTH, 32'h40);
      sw(1'b0, "host threshold trip");
      rd(`EFS_OFS_STAT, 32'h1 << `EFS_ST_TSD, "status tsd");
      wr(`EFS_OFS_OTTH, 32'hFF);
      wr(`EFS_OFS_CTRL, 32'h1 << `EFS_CTRL_RETRY);
      restart();
      @(posedge hclk) thermal_shutdown_hot <= 1'b1;
      thermal_shutdown_cool <= 1'b0;
      sw(1'b0, "retry trip");
      @(posedge hclk) thermal_shutdown_hot <= 1'b0;
      repeat (40) @(posedge hclk);
      chk("held while warm", 32'h0, 32'(switch_on));
      thermal_shutdown_cool <= 1'b1;
      sw(1'b1, "auto restart");
      $display("test thermal done");
   endtask
   task automatic results();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ceiling well above the few hundred cycles the tests need
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         results();
      end
   end
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      restart();
      t_load_current_monitor();
      t_tran();
      t_faults();
      t_limit();
      t_temp();
      results();
   end
endmodule
